// ===== rtl/registered_bus_transceiver.sv
// Functional notes
// - Two eight-bit ports A and B, each with its own storage register.
// - Capture clock rising edge loads A into A register, B into B register.
// - Capture happens on every rising edge regardless of drive enable or direction.
// - With outputs disabled, the input path still feeds the registers.
// - Drive disabled and no capture edge: no port driven, registers hold.
// - At most one port is driven; the other acts as input.
// - With drive enabled, direction low drives A, direction high drives B.
// - Drive A, A-source select low: A follows live B value.
// - Drive A, A-source select high: A carries the B register.
// - Drive B, B-source select low: B follows live A value.
// - Drive B, B-source select high: B carries the A register.
// - The undriven port value may be captured into its own register while the other port is driven.
// - Capture never changes which port is driven; only enable and direction do.
`timescale 1ns/1ps
`default_nettype none
`include "bus_xcvr_map.svh"
module registered_bus_transceiver
    import bus_xcvr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic       drive_enable_n,
    input  wire logic       direction,
    input  wire logic       a_side_capture_clock,
    input  wire logic       b_side_capture_clock,
    input  wire logic       a_output_source_select,
    input  wire logic       b_output_source_select,
    input  wire logic [7:0] port_a_lines_in,
    output logic      [7:0] port_a_lines_out,
    output logic            port_a_lines_oe,
    input  wire logic [7:0] port_b_lines_in,
    output logic      [7:0] port_b_lines_out,
    output logic            port_b_lines_oe,
    output logic      [7:0] a_store,
    output logic      [7:0] b_store
);
    // Inputs are synchronous, so live data passes with one register stage
    // to keep every output straight from a flip-flop.
    logic   a_capture;
    logic   b_capture;
    drive_e next_drive;
    byte_t  next_a_out;
    byte_t  next_b_out;

    capture_edge a_edge (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .level (a_side_capture_clock),
        .rise  (a_capture)
    );

    capture_edge b_edge (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .level (b_side_capture_clock),
        .rise  (b_capture)
    );

    function automatic drive_e decode_drive(input logic oe_n, input logic dir);
        if (oe_n) begin
            decode_drive = DRIVE_NONE;
        end else if (dir == `XCVR_DIR_TO_B) begin
            decode_drive = DRIVE_B;
        end else begin
            decode_drive = DRIVE_A;
        end
    endfunction

    // Storage reset value is only for simulation cleanliness; software must
    // treat contents as undefined before the first capture.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            a_store <= `XCVR_STORE_RESET;
        end else if (ce && a_capture) begin
            a_store <= port_a_lines_in;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            b_store <= `XCVR_STORE_RESET;
        end else if (ce && b_capture) begin
            b_store <= port_b_lines_in;
        end
    end

    always_comb begin
        next_drive = decode_drive(drive_enable_n, direction);
        if (a_output_source_select == `XCVR_SRC_STORED) begin
            next_a_out = b_capture ? port_b_lines_in : b_store;
        end else begin
            next_a_out = port_b_lines_in;
        end
        if (b_output_source_select == `XCVR_SRC_STORED) begin
            next_b_out = a_capture ? port_a_lines_in : a_store;
        end else begin
            next_b_out = port_a_lines_in;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_a_lines_oe <= 1'b0;
            port_b_lines_oe <= 1'b0;
        end else if (ce) begin
            case (next_drive)
                DRIVE_A: begin
                    port_a_lines_oe <= 1'b1;
                    port_b_lines_oe <= 1'b0;
                end
                DRIVE_B: begin
                    port_a_lines_oe <= 1'b0;
                    port_b_lines_oe <= 1'b1;
                end
                default: begin
                    port_a_lines_oe <= 1'b0;
                    port_b_lines_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_a_lines_out <= 8'h00;
            port_b_lines_out <= 8'h00;
        end else if (ce) begin
            port_a_lines_out <= next_a_out;
            port_b_lines_out <= next_b_out;
        end
    end

    a_one_driver: assert property (@(posedge clk) disable iff (reset)
        !(port_a_lines_oe && port_b_lines_oe))
        else $error("both ports driven");

    a_drive_select: assert property (@(posedge clk) disable iff (reset)
        ce |=> (port_a_lines_oe == ($past(!drive_enable_n) && !$past(direction)))
            && (port_b_lines_oe == ($past(!drive_enable_n) && $past(direction))))
        else $error("drive enable mismatch");

    a_isolate_hold: assert property (@(posedge clk) disable iff (reset)
        (ce && drive_enable_n && !a_capture && !b_capture)
            |=> !port_a_lines_oe && !port_b_lines_oe && $stable(a_store) && $stable(b_store))
        else $error("isolation not held");

    a_capture_a: assert property (@(posedge clk) disable iff (reset)
        (ce && a_capture) |=> a_store == $past(port_a_lines_in))
        else $error("A capture missed");

    a_capture_b: assert property (@(posedge clk) disable iff (reset)
        (ce && b_capture) |=> b_store == $past(port_b_lines_in))
        else $error("B capture missed");

    a_live_to_a: assert property (@(posedge clk) disable iff (reset)
        (ce && !a_output_source_select) |=> port_a_lines_out == $past(port_b_lines_in))
        else $error("live B not on A");

    a_live_to_b: assert property (@(posedge clk) disable iff (reset)
        (ce && !b_output_source_select) |=> port_b_lines_out == $past(port_a_lines_in))
        else $error("live A not on B");

    a_stored_to_a: assert property (@(posedge clk) disable iff (reset)
        (ce && a_output_source_select) |=> port_a_lines_out == b_store)
        else $error("stored B not on A");

    a_stored_to_b: assert property (@(posedge clk) disable iff (reset)
        (ce && b_output_source_select) |=> port_b_lines_out == a_store)
        else $error("stored A not on B");

    // Building blocks for the multi-step checks below

    sequence s_a_edge;
        ce && a_capture;
    endsequence

    sequence s_b_edge;
        ce && b_capture;
    endsequence

    sequence s_isolated;
        ce && drive_enable_n;
    endsequence

    sequence s_frozen;
        !ce;
    endsequence

    sequence s_a_kept;
        $stable(a_store);
    endsequence

    sequence s_b_kept;
        $stable(b_store);
    endsequence

    sequence s_lines_kept;
        $stable(port_a_lines_oe) && $stable(port_b_lines_oe)
            && $stable(port_a_lines_out) && $stable(port_b_lines_out);
    endsequence

    // Clock enable low must freeze everything, edge detectors included,
    // otherwise a capture edge could be lost or applied twice.

    a_freeze_a_store: assert property (@(posedge clk) disable iff (reset)
        s_frozen |=> s_a_kept)
        else $error("A register moved while frozen");

    a_freeze_b_store: assert property (@(posedge clk) disable iff (reset)
        s_frozen |=> s_b_kept)
        else $error("B register moved while frozen");

    a_freeze_lines: assert property (@(posedge clk) disable iff (reset)
        s_frozen |=> s_lines_kept)
        else $error("port drive moved while frozen");

    // Storing must work with the outputs off

    a_isolated_store_a: assert property (@(posedge clk) disable iff (reset)
        s_isolated ##0 s_a_edge |=> a_store == $past(port_a_lines_in))
        else $error("A not stored while isolated");

    a_isolated_store_b: assert property (@(posedge clk) disable iff (reset)
        s_isolated ##0 s_b_edge |=> b_store == $past(port_b_lines_in))
        else $error("B not stored while isolated");

    a_both_stored: assert property (@(posedge clk) disable iff (reset)
        (ce && drive_enable_n && a_capture && b_capture)
            |=> (a_store == $past(port_a_lines_in)) && (b_store == $past(port_b_lines_in)))
        else $error("dual capture missed");

    // Without an edge the registers hold

    a_a_store_hold: assert property (@(posedge clk) disable iff (reset)
        (ce && !a_capture) |=> s_a_kept)
        else $error("A register changed without edge");

    a_b_store_hold: assert property (@(posedge clk) disable iff (reset)
        (ce && !b_capture) |=> s_b_kept)
        else $error("B register changed without edge");

    // Capturing must not steer the drivers

    a_capture_no_steer: assert property (@(posedge clk) disable iff (reset)
        (ce && (a_capture || b_capture))
            |=> (port_a_lines_oe == $past(!drive_enable_n && !direction))
                && (port_b_lines_oe == $past(!drive_enable_n && direction)))
        else $error("capture changed drive");

    // The port that is an input may be stored while the other is driven

    a_undriven_a_store: assert property (@(posedge clk) disable iff (reset)
        (ce && a_capture && !drive_enable_n && direction)
            |=> a_store == $past(port_a_lines_in))
        else $error("undriven A not stored");

    a_undriven_b_store: assert property (@(posedge clk) disable iff (reset)
        (ce && b_capture && !drive_enable_n && !direction)
            |=> b_store == $past(port_b_lines_in))
        else $error("undriven B not stored");

    // Edge detection: a capture needs the pin low on the previous enabled
    // cycle. Just after reset the detector starts low, so a pin already
    // high then counts as an edge; that cycle is left out here.

    a_edge_after_low_a: assert property (@(posedge clk) disable iff (reset)
        (a_capture && $past(ce) && !$past(reset)) |-> !$past(a_side_capture_clock))
        else $error("A capture without low phase");

    a_edge_after_low_b: assert property (@(posedge clk) disable iff (reset)
        (b_capture && $past(ce) && !$past(reset)) |-> !$past(b_side_capture_clock))
        else $error("B capture without low phase");

    a_edge_seen_a: assert property (@(posedge clk) disable iff (reset)
        (ce && a_side_capture_clock && $past(ce) && !$past(a_side_capture_clock))
            |-> a_capture)
        else $error("A rising edge missed");

    a_edge_seen_b: assert property (@(posedge clk) disable iff (reset)
        (ce && b_side_capture_clock && $past(ce) && !$past(b_side_capture_clock))
            |-> b_capture)
        else $error("B rising edge missed");

    // Stored source in the capture cycle shows the word being stored,
    // so the driven port and the register never disagree.

    a_forward_to_b: assert property (@(posedge clk) disable iff (reset)
        (ce && b_output_source_select && a_capture)
            |=> port_b_lines_out == $past(port_a_lines_in))
        else $error("A capture not forwarded");

    a_forward_to_a: assert property (@(posedge clk) disable iff (reset)
        (ce && a_output_source_select && b_capture)
            |=> port_a_lines_out == $past(port_b_lines_in))
        else $error("B capture not forwarded");
endmodule
`default_nettype wire

// ===== rtl/bus_xcvr_map.svh
`ifndef BUS_XCVR_MAP_SVH
`define BUS_XCVR_MAP_SVH

`define XCVR_DATA_WIDTH      8
`define XCVR_STORE_RESET     8'h00
`define XCVR_SRC_LIVE        1'b0
`define XCVR_SRC_STORED      1'b1
`define XCVR_DIR_TO_A        1'b0
`define XCVR_DIR_TO_B        1'b1

`endif

// ===== rtl/bus_xcvr_pkg.sv
package bus_xcvr_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        DRIVE_NONE = 2'b00,
        DRIVE_A    = 2'b01,
        DRIVE_B    = 2'b11
    } drive_e;
endpackage

// ===== rtl/capture_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Rising-edge detector for a capture clock sampled as a synchronous input
module capture_edge (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ce,
    input  wire logic level,
    output logic      rise
);
    logic last;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last <= 1'b0;
        end else if (ce) begin
            last <= level;
        end
    end

    assign rise = ce & level & ~last;
endmodule
`default_nettype wire

// ===== verif/far_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_bus_model
    import bus_xcvr_pkg::*;
(
    input  wire logic  a_oe,
    input  wire byte_t a_out,
    input  wire byte_t ext_a,
    input  wire logic  b_oe,
    input  wire byte_t b_out,
    input  wire byte_t ext_b,
    output var  byte_t a_in,
    output var  byte_t b_in
);
    // Outside logic lets go of a port while the transceiver drives it
    assign a_in = a_oe ? a_out : ext_a;
    assign b_in = b_oe ? b_out : ext_b;
endmodule
`default_nettype wire

// ===== verif/registered_bus_transceiver_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module registered_bus_transceiver_tb_top
    import bus_xcvr_pkg::*;
;
    logic  clk = 1'b0, reset = 1'b1, den_n = 1'b1, dir = 1'b0;
    logic  cap_a = 1'b0, cap_b = 1'b0, sel_a = 1'b0, sel_b = 1'b0;
    logic  a_oe, b_oe, ce = 1'b1;
    byte_t ext_a = 8'h00, ext_b = 8'h00;
    byte_t a_in, b_in, a_out, b_out, a_store, b_store;
    int    n_errors = 0;
    int    num_checks = 0;

    initial forever #4 clk = ~clk;

    registered_bus_transceiver uut (.clk(clk), .reset(reset), .ce(ce),
        .drive_enable_n(den_n), .direction(dir), .a_side_capture_clock(cap_a),
        .b_side_capture_clock(cap_b), .a_output_source_select(sel_a),
        .b_output_source_select(sel_b), .port_a_lines_in(a_in), .port_a_lines_out(a_out),
        .port_a_lines_oe(a_oe), .port_b_lines_in(b_in), .port_b_lines_out(b_out),
        .port_b_lines_oe(b_oe), .a_store(a_store), .b_store(b_store));

    far_bus_model far (.a_oe(a_oe), .a_out(a_out), .ext_a(ext_a), .b_oe(b_oe),
        .b_out(b_out), .ext_b(ext_b), .a_in(a_in), .b_in(b_in));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic capture(input logic do_a, input logic do_b);
        @(negedge clk);
        cap_a = do_a;
        cap_b = do_b;
        @(negedge clk);
        cap_a = 1'b0;
        cap_b = 1'b0;
    endtask

    task automatic test_isolation();
        ext_a = 8'ha5;
        ext_b = 8'h3c;
        capture(1'b1, 1'b1);
        check(a_store, 8'ha5);
        check(b_store, 8'h3c);
        check({6'h00, a_oe, b_oe}, 8'h00);
    endtask

    task automatic test_hold();
        @(negedge clk);
        cap_a = 1'b1;
        cap_b = 1'b1;
        ext_a = 8'h5a;
        ext_b = 8'hc3;
        @(negedge clk);
        ext_a = 8'h0f;
        ext_b = 8'hf0;
        repeat (3) @(negedge clk);
        check(a_store, 8'h5a);
        check(b_store, 8'hc3);
        check({6'h00, a_oe, b_oe}, 8'h00);
        cap_a = 1'b0;
        cap_b = 1'b0;
    endtask

    task automatic test_freeze();
        @(negedge clk);
        ce = 1'b0;
        cap_a = 1'b1;
        ext_a = 8'h77;
        repeat (2) @(negedge clk);
        check(a_store, 8'h5a);
        ce = 1'b1;
        cap_a = 1'b0;
    endtask

    task automatic test_modes();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            den_n = 1'b0;
            dir = i[1];
            sel_a = i[0];
            sel_b = i[0];
            ext_a = 8'h40 | 8'(i);
            ext_b = 8'h80 | 8'(i);
            // One extra cycle lets a port that was driven turn round
            repeat (2) @(negedge clk);
            check({6'h00, a_oe, b_oe}, {6'h00, ~i[1], i[1]});
            if (i == 0) check(a_out, 8'h80);
            if (i == 1) check(a_out, 8'hc3);
            if (i == 2) check(b_out, 8'h42);
            if (i == 3) check(b_out, 8'h5a);
        end
        // Capture the undriven side while A shows the stored B value
        dir = 1'b0;
        sel_a = 1'b1;
        ext_b = 8'h96;
        capture(1'b0, 1'b1);
        check(b_store, 8'h96);
        check(a_out, 8'h96);
        check({6'h00, a_oe, b_oe}, 8'h02);
        den_n = 1'b1;
        @(negedge clk);
        check({6'h00, a_oe, b_oe}, 8'h00);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        summarize();
    end

    initial begin
        repeat (10) @(negedge clk);
        reset = 1'b0;
        test_isolation();
        test_hold();
        test_freeze();
        test_modes();
        summarize();
    end
endmodule
`default_nettype wire
